// ---- inc/cag_pkg.sv ----
// Constants and types for the CPU address generation block
package cag_pkg;
    localparam logic [15:0] TABLE_BASE = 16'h0040;
    localparam logic [15:0] TABLE_LAST = 16'h007F;
    localparam logic [15:0] SHORT_CALL_BASE = 16'h0800;
    localparam logic [7:0] SADDR_HI = 8'hFE;
    localparam logic [7:0] SADDR_WRAP = 8'h20;
    localparam logic [15:0] SADDR_FIRST = 16'hFE20;
    localparam logic [15:0] SADDR_LAST = 16'hFF1F;
    localparam logic [15:0] RAM_FIRST = 16'hFE20;
    localparam logic [15:0] RAM_LAST = 16'hFEFF;
    localparam logic [15:0] SFR_FIRST = 16'hFF00;
    localparam logic [7:0] SFR_HI = 8'hFF;
    localparam logic [7:0] SFR_GAP_LO = 8'hD0;
    localparam logic [7:0] SFR_GAP_HI = 8'hDF;
    localparam logic [15:0] HSRAM_FIRST = 16'hFB00;
    localparam logic [15:0] HSRAM_LAST = 16'hFEFF;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [1:0] RP_AX = 2'h0;
    localparam logic [1:0] RP_HL = 2'h3;

    // Address mode requested by the decoder
    typedef enum logic [3:0] {
        AM_NONE = 4'h0,
        AM_TABLE = 4'h1,
        AM_REGJMP = 4'h2,
        AM_IMPLIED = 4'h3,
        AM_REG = 4'h4,
        AM_DIRECT = 4'h5,
        AM_SHORT = 4'h6,
        AM_SFR = 4'h7,
        AM_INDIRECT = 4'h8,
        AM_BASED = 4'h9,
        AM_BASED_IDX = 4'hA,
        AM_STACK = 4'hB,
        AM_SHORTCALL = 4'hC,
        AM_CALL16 = 4'hD
    } cag_mode_t;

    // Implied accumulator operation
    typedef enum logic [2:0] {
        IMP_MUL = 3'h0,
        IMP_DIV = 3'h1,
        IMP_ADJ_ADD = 3'h2,
        IMP_ADJ_SUB = 3'h3,
        IMP_NIB_LEFT = 3'h4,
        IMP_NIB_RIGHT = 3'h5
    } cag_imp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TBL_LO = 3'b010,
        ST_TBL_HI = 3'b100
    } cag_state_t;
endpackage

// ---- src/cag_regsel.sv ----
// Banked register and register pair selector
`timescale 1ns/1ps
module cag_regsel
    import cag_pkg::*;
(
    input wire logic [255:0] regs_i,
    input wire logic bank_select_lo_i,
    input wire logic bank_select_hi_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [1:0] pair_sel_i,
    output logic [7:0] reg_o,
    output logic [15:0] pair_o,
    output logic [4:0] reg_index_o
);
    logic [1:0] bank;
    logic [4:0] pidx;

    always_comb begin
        bank = {bank_select_hi_i, bank_select_lo_i};
        reg_index_o = {bank, reg_sel_i};
        pidx = {bank, pair_sel_i, 1'b0};
        // Pair n is registers 2n (low) and 2n+1 (high): X/A, C/B, E/D, L/H
        reg_o = regs_i[reg_index_o*8 +: 8];
        pair_o = {regs_i[(pidx + 5'd1)*8 +: 8], regs_i[pidx*8 +: 8]};
    end
endmodule

// ---- src/cag_short_map.sv ----
// Short direct and SFR effective address mapping
`timescale 1ns/1ps
module cag_short_map
    import cag_pkg::*;
(
    input wire logic [7:0] imm_i,
    input wire logic sfr_mode_i,
    input wire logic word_i,
    output logic [15:0] addr_o,
    output logic illegal_o
);
    logic odd;

    always_comb begin
        odd = word_i & imm_i[0];
        if (sfr_mode_i) begin
            addr_o = {SFR_HI, imm_i};
            // Interrupt and gap area between FFD0 and FFDF is not SFR space
            illegal_o = odd || (imm_i >= SFR_GAP_LO && imm_i <= SFR_GAP_HI);
        end else begin
            // Bit 8 set for 00-1F so the window wraps to FF00-FF1F
            addr_o = {SADDR_HI[7:1], imm_i < SADDR_WRAP, imm_i};
            illegal_o = odd;
        end
        if (sfr_mode_i) begin
            illegal_o = illegal_o | odd;
        end
    end
endmodule

// ---- src/cag_top.sv ----
// CPU address generation: branch targets and operand addresses
// Notes on behaviour
// - Table call uses opcode bits 1..5 to pick entry, loads it into PC.
// - Vector table lives at 40H-7FH; targets may be anywhere.
// - Register jump copies the AX pair into PC.
// - Multiply takes A, multiplies by named register, product to AX.
// - Word divide reads dividend from AX, writes quotient back to AX.
// - Decimal adjust ops use A as both source and destination.
// - Nibble rotates keep the rotated digit data in A.
// - Bank chosen by two bank-select flags; 3-bit field picks register.
// - Registers X,A,C,B,E,D,L,H are R0-pairs AX,BC,DE,HL are RP0-RP3.
// - Direct mode uses the 16-bit immediate unchanged as address.
// - Short direct reaches FE20H-FF1FH from an 8-bit immediate.
// - Short direct high byte FEH, bit 8 set only for 00H-1FH.
// - RAM sits at FE20H-FEFFH, SFRs at FF00H-FF1FH in that window.
// - Word short direct accepts only even addresses.
// - SFR mode maps immediate to FF00-FFFF, high byte FFH; FFD0-FFDF is flagged as an error.
// - Word SFR access selects only even addresses.
// - Register indirect uses the selected banked pair as full address.
// - Based mode adds zero-extended offset to HL, carry dropped.
// - Based indexed adds zero-extended B or C to HL, carry dropped.
// - Push, pop, call, return, interrupt save address through SP.
// - Stack accesses outside internal high-speed RAM are flagged, not remapped.
// - Short call reaches only 0800H-0FFFH; 16-bit call reaches all.
`timescale 1ns/1ps
module cag_top
    import cag_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] mode_i,
    input wire logic [2:0] imp_op_i,
    input wire logic [7:0] opcode_i,
    input wire logic [15:0] imm16_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [1:0] pair_sel_i,
    input wire logic word_i,
    input wire logic bank_select_lo_i,
    input wire logic bank_select_hi_i,
    input wire logic [255:0] regs_i,
    input wire logic [15:0] sp_i,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [15:0] addr_o,
    output logic addr_valid_o,
    output logic addr_error_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic mem_rd_o,
    output logic [15:0] mem_addr_o,
    output logic busy_o,
    output logic [4:0] src_reg_o,
    output logic [4:0] dst_reg_o,
    output logic dst_pair_o,
    output logic [7:0] operand_o,
    output logic [15:0] operand_pair_o
);
    typedef struct packed {
        cag_state_t state;
        logic [15:0] addr;
        logic addr_valid;
        logic addr_error;
        logic [15:0] pc;
        logic pc_load;
        logic mem_rd;
        logic busy;
        logic [15:0] mem_addr;
        logic [7:0] tbl_lo;
        logic [4:0] src_reg;
        logic [4:0] dst_reg;
        logic dst_pair;
        logic [7:0] operand;
        logic [15:0] operand_pair;
    } cag_state_reg_t;

    cag_state_reg_t st;
    cag_state_reg_t next_st;

    logic [7:0] sel_reg;
    logic [15:0] sel_pair;
    logic [4:0] sel_index;
    logic [7:0] idx_reg;
    logic [15:0] idx_pair;
    logic [7:0] acc_reg;
    logic [15:0] acc_pair;
    logic [15:0] short_addr;
    logic short_bad;
    logic [1:0] bank;
    logic [4:0] a_index;
    logic [4:0] ax_index;
    logic [4:0] tbl_index;
    logic [15:0] tbl_entry;
    logic [15:0] short_call_target;
    logic [16:0] based_sum;
    logic [16:0] based_idx_sum;
    logic direct_odd;
    logic stack_out;
    cag_mode_t mode;

    // Operand register or pair chosen by the opcode field
    cag_regsel u_sel (
        .regs_i(regs_i),
        .bank_select_lo_i(bank_select_lo_i),
        .bank_select_hi_i(bank_select_hi_i),
        .reg_sel_i(reg_sel_i),
        .pair_sel_i(pair_sel_i),
        .reg_o(sel_reg),
        .pair_o(sel_pair),
        .reg_index_o(sel_index)
    );

    // Base pair HL and index B or C for based modes
    cag_regsel u_idx (
        .regs_i(regs_i),
        .bank_select_lo_i(bank_select_lo_i),
        .bank_select_hi_i(bank_select_hi_i),
        .reg_sel_i(reg_sel_i[0] ? REG_B : REG_C),
        .pair_sel_i(RP_HL),
        .reg_o(idx_reg),
        .pair_o(idx_pair),
        .reg_index_o()
    );

    // Accumulator A and pair AX for implied operands and register jump
    cag_regsel u_acc (
        .regs_i(regs_i),
        .bank_select_lo_i(bank_select_lo_i),
        .bank_select_hi_i(bank_select_hi_i),
        .reg_sel_i(REG_A),
        .pair_sel_i(RP_AX),
        .reg_o(acc_reg),
        .pair_o(acc_pair),
        .reg_index_o(a_index)
    );

    cag_short_map u_short (
        .imm_i(imm16_i[7:0]),
        .sfr_mode_i(mode == AM_SFR),
        .word_i(word_i),
        .addr_o(short_addr),
        .illegal_o(short_bad)
    );

    always_comb begin
        mode = cag_mode_t'(mode_i);
        bank = {bank_select_hi_i, bank_select_lo_i};
        ax_index = {bank, RP_AX, 1'b0};
        // Entry word at 40H + 2*index, always inside 40H-7FH
        tbl_index = opcode_i[5:1];
        tbl_entry = TABLE_BASE | {10'h000, tbl_index, 1'b0};
        // Upper bits forced, so the target never leaves 0800H-0FFFH
        short_call_target = SHORT_CALL_BASE | {5'h00, imm16_i[10:0]};
        // Bit 16 is the carry out; only the low 16 bits are used
        based_sum = {1'b0, idx_pair} + {9'h000, imm16_i[7:0]};
        based_idx_sum = {1'b0, idx_pair} + {9'h000, idx_reg};
        direct_odd = word_i & imm16_i[0];
        // Outside high-speed RAM is flagged, not remapped
        stack_out = (sp_i < HSRAM_FIRST) || (sp_i > HSRAM_LAST);
    end

    always_comb begin
        next_st = st;
        next_st.addr_valid = 1'b0;
        next_st.pc_load = 1'b0;
        case (st.state)
            ST_IDLE: begin
                if (start_i) begin
                    next_st.addr_error = 1'b0;
                    next_st.dst_pair = 1'b0;
                    case (mode)
                        AM_TABLE: begin
                            next_st.mem_addr = tbl_entry;
                            next_st.mem_rd = 1'b1;
                            next_st.state = ST_TBL_LO;
                        end
                        AM_REGJMP: begin
                            next_st.pc = acc_pair;
                            next_st.pc_load = 1'b1;
                        end
                        AM_SHORTCALL: begin
                            next_st.pc = short_call_target;
                            next_st.pc_load = 1'b1;
                        end
                        AM_CALL16: begin
                            next_st.pc = imm16_i;
                            next_st.pc_load = 1'b1;
                        end
                        AM_IMPLIED: begin
                            next_st.src_reg = a_index;
                            next_st.dst_reg = a_index;
                            next_st.operand = acc_reg;
                            next_st.operand_pair = acc_pair;
                            case (cag_imp_t'(imp_op_i))
                                IMP_MUL: begin
                                    next_st.operand = sel_reg;
                                    next_st.dst_reg = ax_index;
                                    next_st.dst_pair = 1'b1;
                                end
                                IMP_DIV: begin
                                    next_st.src_reg = ax_index;
                                    next_st.dst_reg = ax_index;
                                    next_st.dst_pair = 1'b1;
                                end
                                IMP_ADJ_ADD, IMP_ADJ_SUB: begin
                                    // Value corrected in place in A
                                    next_st.src_reg = a_index;
                                    next_st.dst_reg = a_index;
                                end
                                IMP_NIB_LEFT, IMP_NIB_RIGHT: begin
                                    // Digit data rotated through A
                                    next_st.src_reg = a_index;
                                    next_st.dst_reg = a_index;
                                end
                                default: begin
                                end
                            endcase
                            next_st.addr_valid = 1'b1;
                        end
                        AM_REG: begin
                            next_st.src_reg = sel_index;
                            next_st.dst_reg = sel_index;
                            next_st.operand = sel_reg;
                            next_st.operand_pair = sel_pair;
                            next_st.addr_valid = 1'b1;
                        end
                        AM_DIRECT: begin
                            next_st.addr = imm16_i;
                            next_st.addr_error = direct_odd;
                            next_st.addr_valid = 1'b1;
                        end
                        AM_SHORT, AM_SFR: begin
                            next_st.addr = short_addr;
                            next_st.addr_error = short_bad;
                            next_st.addr_valid = 1'b1;
                        end
                        AM_INDIRECT: begin
                            next_st.addr = sel_pair;
                            next_st.addr_valid = 1'b1;
                        end
                        AM_BASED: begin
                            next_st.addr = based_sum[15:0];
                            next_st.addr_valid = 1'b1;
                        end
                        AM_BASED_IDX: begin
                            next_st.addr = based_idx_sum[15:0];
                            next_st.addr_valid = 1'b1;
                        end
                        AM_STACK: begin
                            next_st.addr = sp_i;
                            next_st.addr_error = stack_out;
                            next_st.addr_valid = 1'b1;
                        end
                        AM_NONE: begin
                            // No operand this cycle; addr_error and dst_pair clear, addresses and operands keep their value
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_TBL_LO: begin
                if (mem_ack_i) begin
                    next_st.tbl_lo = mem_rdata_i;
                    next_st.mem_addr = st.mem_addr + 16'h0001;
                    next_st.state = ST_TBL_HI;
                end
            end
            ST_TBL_HI: begin
                if (mem_ack_i) begin
                    // Destination may lie anywhere in 64 KB
                    next_st.pc = {mem_rdata_i, st.tbl_lo};
                    next_st.pc_load = 1'b1;
                    next_st.mem_rd = 1'b0;
                    next_st.state = ST_IDLE;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
                next_st.mem_rd = 1'b0;
            end
        endcase
        // Registered so busy_o leaves a flip-flop directly
        next_st.busy = next_st.state != ST_IDLE;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.pc <= RST_ADDR;
            st.addr <= RST_ADDR;
            st.mem_addr <= RST_ADDR;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        addr_o = st.addr;
        addr_valid_o = st.addr_valid;
        addr_error_o = st.addr_error;
        pc_o = st.pc;
        pc_load_o = st.pc_load;
        mem_rd_o = st.mem_rd;
        mem_addr_o = st.mem_addr;
        busy_o = st.busy;
        src_reg_o = st.src_reg;
        dst_reg_o = st.dst_reg;
        dst_pair_o = st.dst_pair;
        operand_o = st.operand;
        operand_pair_o = st.operand_pair;
    end
endmodule

// ---- sim/cag_monitor.sv ----
// Assertion checker for the address generation block
`timescale 1ns/1ps
module cag_monitor
    import cag_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] mode_i,
    input wire logic [7:0] opcode_i,
    input wire logic [15:0] imm16_i,
    input wire logic bank_select_lo_i,
    input wire logic bank_select_hi_i,
    input wire logic [255:0] regs_i,
    input wire logic [15:0] sp_i,
    input wire logic busy_o,
    input wire logic [15:0] addr_o,
    input wire logic addr_valid_o,
    input wire logic addr_error_o,
    input wire logic [15:0] pc_o,
    input wire logic pc_load_o,
    input wire logic mem_rd_o,
    input wire logic [15:0] mem_addr_o
);
    logic [1:0] bk;
    logic [15:0] hl;
    logic [15:0] ax;
    logic tk;
    assign bk = {bank_select_hi_i, bank_select_lo_i};
    assign hl = regs_i[bk*64+48+:16];
    assign ax = regs_i[bk*64+:16];
    assign tk = start_i && !busy_o;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_short;
        tk && mode_i == AM_SHORT |=> addr_valid_o && addr_o ==
            {7'h7F, $past(imm16_i[7:0]) < 8'h20, $past(imm16_i[7:0])};
    endproperty
    a_short: assert property (p_short) else $error("short addr");
    property p_sfr;
        tk && mode_i == AM_SFR |=> addr_o == {8'hFF, $past(imm16_i[7:0])};
    endproperty
    a_sfr: assert property (p_sfr) else $error("sfr addr");
    property p_direct;
        tk && mode_i == AM_DIRECT |=> addr_valid_o && addr_o == $past(imm16_i);
    endproperty
    a_direct: assert property (p_direct) else $error("direct addr");
    property p_based;
        tk && mode_i == AM_BASED |=>
            addr_o == $past(hl) + {8'h00, $past(imm16_i[7:0])};
    endproperty
    a_based: assert property (p_based) else $error("based addr");
    property p_stack;
        tk && mode_i == AM_STACK |=> addr_o == $past(sp_i) && addr_error_o ==
            ($past(sp_i) < HSRAM_FIRST || $past(sp_i) > HSRAM_LAST);
    endproperty
    a_stack: assert property (p_stack) else $error("stack addr");
    property p_regjmp;
        tk && mode_i == AM_REGJMP |=> pc_load_o && pc_o == $past(ax);
    endproperty
    a_regjmp: assert property (p_regjmp) else $error("reg jump");
    property p_scall;
        tk && mode_i == AM_SHORTCALL |=>
            pc_load_o && pc_o == {5'h01, $past(imm16_i[10:0])};
    endproperty
    a_scall: assert property (p_scall) else $error("short call");
    property p_table;
        tk && mode_i == AM_TABLE |=> mem_rd_o && busy_o &&
            mem_addr_o == TABLE_BASE + {$past(opcode_i[5:1]), 1'b0};
    endproperty
    a_table: assert property (p_table) else $error("table fetch");
endmodule

// ---- sim/cag_top_tb_top.sv ----
// Self-checking bench for the address generation block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module cag_top_tb_top
    import cag_pkg::*;
;
    logic clk_sys_i, rst_i, start_i, word_i, mem_ack_i;
    logic bank_select_lo_i, bank_select_hi_i, busy_o, dst_pair_o;
    logic [3:0] mode_i;
    logic [2:0] imp_op_i, reg_sel_i;
    logic [1:0] pair_sel_i;
    logic [7:0] opcode_i, mem_rdata_i, operand_o;
    logic [15:0] imm16_i, sp_i, addr_o, pc_o, mem_addr_o, operand_pair_o;
    logic [255:0] regs_i;
    logic addr_valid_o, addr_error_o, pc_load_o, mem_rd_o;
    logic [4:0] src_reg_o, dst_reg_o;
    int n_mismatch, compares;
    cag_top uut (.*);
    initial begin
        clk_sys_i = 0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [7:0] rb(input int i);
        return regs_i[i*8+:8];
    endfunction
    function automatic logic [15:0] rp(input int b, input int p);
        return {rb(b*8+2*p+1), rb(b*8+2*p)};
    endfunction
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Lets one edge pass so start never drops and rises in one step,
    // then pulses start; outputs are checked at the falling edge on return
    task automatic go(input logic [3:0] m, input logic [15:0] im);
        @(negedge clk_sys_i);
        mode_i = m;
        imm16_i = im;
        start_i = 1;
        @(negedge clk_sys_i);
        start_i = 0;
    endtask
    task automatic bank(input logic [1:0] b);
        {bank_select_hi_i, bank_select_lo_i} = b;
    endtask
    task automatic ck_addr(input logic [15:0] ea, input logic ee);
        `CHK("addr_valid", 1'b1, addr_valid_o)
        `CHK("addr", ea, addr_o)
        `CHK("addr_error", ee, addr_error_o)
    endtask
    // Slow memory: stalls two cycles and tries a start meanwhile
    task automatic fetch(input logic [15:0] a, input logic [7:0] d);
        int n = 0;
        while (mem_rd_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (mem_rd_o !== 1'b1) begin
            n_mismatch++;
            results();
        end
        `CHK("mem_addr", a, mem_addr_o)
        `CHK("busy", 1'b1, busy_o)
        @(negedge clk_sys_i);
        start_i = 1;
        mode_i = AM_DIRECT;
        @(negedge clk_sys_i);
        start_i = 0;
        mem_ack_i = 1;
        mem_rdata_i = d;
        `CHK("refused", 1'b0, addr_valid_o)
        @(negedge clk_sys_i);
        mem_ack_i = 0;
    endtask
    task automatic t_short();
        logic [7:0] im[5] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'h80};
        foreach (im[i]) begin
            go(AM_SHORT, {8'h00, im[i]});
            ck_addr({7'h7F, im[i] < 8'h20, im[i]}, 0);
            go(AM_SFR, {8'h00, im[i]});
            ck_addr({8'hFF, im[i]}, 0);
        end
        word_i = 1;
        go(AM_SHORT, 16'h0021);
        ck_addr(16'hFE21, 1);
        go(AM_SHORT, 16'h0010);
        ck_addr(16'hFF10, 0);
        go(AM_SFR, 16'h0021);
        ck_addr(16'hFF21, 1);
        word_i = 0;
        go(AM_SFR, 16'h00D0);
        ck_addr(16'hFFD0, 1);
        go(AM_SFR, 16'h00DF);
        ck_addr(16'hFFDF, 1);
        go(AM_DIRECT, 16'hFE01);
        ck_addr(16'hFE01, 0);
        $display("test short done");
    endtask
    task automatic t_regs();
        for (int b = 0; b < 4; b++) begin
            bank(b[1:0]);
            for (int r = 0; r < 8; r++) begin
                reg_sel_i = r[2:0];
                pair_sel_i = r[1:0];
                go(AM_REG, 16'h0000);
                `CHK("operand", rb(b*8+r), operand_o)
                `CHK("pair", rp(b, r % 4), operand_pair_o)
                `CHK("src", 5'(b*8+r), src_reg_o)
                go(AM_INDIRECT, 16'h0000);
                ck_addr(rp(b, r % 4), 0);
            end
            go(AM_REGJMP, 16'h0000);
            `CHK("pc_load", 1'b1, pc_load_o)
            `CHK("pc", rp(b, 0), pc_o)
        end
        $display("test regs done");
    endtask
    task automatic t_based();
        logic [15:0] sv[4] = '{16'hFB00, 16'hFEFF, 16'hFAFF, 16'hFF00};
        bank(2'h3);
        reg_sel_i = 3'h0;
        go(AM_BASED, 16'h00FF);
        ck_addr(rp(3, 3) + 16'h00FF, 0);
        go(AM_BASED_IDX, 16'h0000);
        ck_addr(rp(3, 3) + {8'h00, rb(26)}, 0);
        bank(2'h0);
        reg_sel_i = 3'h1;
        go(AM_BASED_IDX, 16'h0000);
        ck_addr(rp(0, 3) + {8'h00, rb(3)}, 0);
        for (int i = 0; i < 4; i++) begin
            sp_i = sv[i];
            go(AM_STACK, 16'h0000);
            ck_addr(sv[i], i > 1);
        end
        $display("test based done");
    endtask
    task automatic t_branch();
        logic [4:0] ix[2] = '{5'h00, 5'h1F};
        foreach (ix[i]) begin
            opcode_i = {2'b11, ix[i], 1'b1};
            go(AM_TABLE, 16'h0000);
            fetch(16'h0040 + {ix[i], 1'b0}, 8'h5A ^ ix[i]);
            fetch(16'h0041 + {ix[i], 1'b0}, 8'hC3);
            `CHK("pc_load", 1'b1, pc_load_o)
            `CHK("pc", {8'hC3, 8'h5A ^ ix[i]}, pc_o)
            `CHK("busy", 1'b0, busy_o)
            `CHK("mem_rd", 1'b0, mem_rd_o)
        end
        go(AM_SHORTCALL, 16'hFFFF);
        `CHK("pc", 16'h0FFF, pc_o)
        go(AM_SHORTCALL, 16'hF000);
        `CHK("pc", 16'h0800, pc_o)
        go(AM_CALL16, 16'hFFFF);
        `CHK("pc", 16'hFFFF, pc_o)
        $display("test branch done");
    endtask
    // Multiply and divide write the pair, the rest stay on A
    task automatic t_implied();
        bank(2'h1);
        reg_sel_i = 3'h4;
        for (int k = 0; k < 6; k++) begin
            imp_op_i = k[2:0];
            go(AM_IMPLIED, 16'h0000);
            `CHK("dst_pair", k < 2, dst_pair_o)
            `CHK("dst", k < 2 ? 5'h08 : 5'h09, dst_reg_o)
            `CHK("src", k == 1 ? 5'h08 : 5'h09, src_reg_o)
            if (k == 0) begin
                `CHK("operand", rb(12), operand_o)
            end else if (k == 1) begin
                `CHK("pair", rp(1, 0), operand_pair_o)
            end
        end
        $display("test implied done");
    endtask
    initial begin
        {rst_i, start_i, word_i, mem_ack_i} = 4'h8;
        {mode_i, imp_op_i, reg_sel_i, pair_sel_i, opcode_i} = '0;
        {mem_rdata_i, imm16_i, sp_i} = '0;
        bank(2'h0);
        for (int i = 0; i < 32; i++) begin
            regs_i[i*8+:8] = 8'(i * 9 + 8'h37);
        end
        // Top byte forces a carry out in the based test
        regs_i[255:248] = 8'hFF;
        repeat (10) @(negedge clk_sys_i);
        rst_i = 0;
        t_short();
        t_regs();
        t_based();
        t_branch();
        t_implied();
        results();
    end
endmodule
bind cag_top cag_monitor u_mon (.*);
